/* bus_master_model.sv */
// Two-wire bus master model: drives the clock line and pulls the data line low
`timescale 1ns/100ps
`default_nettype none
module bus_master_model #(
  parameter int unsigned HALF = 10
) (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // ==========================================================
  // Idle bus
  // Clock stands high between frames, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic wait_cycles(input int unsigned n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // ==========================================================
  // Bit level
  // Data moves halfway through the low phase, clear of both clock edges
  task automatic send_bit(input logic b);
    wait_cycles(HALF / 2);
    sda_pull_o = ~b;
    wait_cycles(HALF / 2);
    scl_o = 1'b1;
    wait_cycles(HALF);
    scl_o = 1'b0;
  endtask

  task automatic read_bit(output logic b);
    wait_cycles(HALF / 2);
    sda_pull_o = 1'b0;
    wait_cycles(HALF / 2);
    scl_o = 1'b1;
    wait_cycles(HALF / 2);
    b = sda_i;
    wait_cycles(HALF / 2);
    scl_o = 1'b0;
  endtask

  // Called mid-frame it becomes a repeated start
  task automatic start_cond();
    if (scl_o === 1'b0) begin
      wait_cycles(HALF / 2);
      sda_pull_o = 1'b0;
      wait_cycles(HALF / 2);
      scl_o = 1'b1;
      wait_cycles(HALF);
    end
    sda_pull_o = 1'b1;
    wait_cycles(HALF);
    scl_o = 1'b0;
  endtask

  task automatic stop_cond();
    wait_cycles(HALF / 2);
    sda_pull_o = 1'b1;
    wait_cycles(HALF / 2);
    scl_o = 1'b1;
    wait_cycles(HALF);
    sda_pull_o = 1'b0;
    wait_cycles(HALF);
  endtask

  // ==========================================================
  // Byte level
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic nack;
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i]);
    end
    read_bit(nack);
    ack = ~nack;
  endtask

  // Acknowledge asks for the next byte; no acknowledge ends the read
  task automatic read_byte(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      read_bit(b[i]);
    end
    send_bit(~ack);
  endtask
endmodule
`default_nettype wire

/* cell_array.sv */
// Storage array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module cell_array #(
  parameter int unsigned ADDR_W = 7,
  parameter int unsigned DATA_W = 8
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] cells_reg [2**ADDR_W];

  always_ff @(posedge clock_i) begin
    if (enable_i && wr_en_i) begin
      cells_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= '0;
    end else if (enable_i) begin
      rd_data_o <= cells_reg[rd_addr_i];
    end
  end
endmodule
`default_nettype wire

/* eeprom_pkg.sv */
// Shared constants and types of the two-wire serial memory slave
package eeprom_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLOCK_HZ = 100_000_000;
  localparam int unsigned PROG_TIME_MS = 1;
  localparam int unsigned PROG_CYCLES = CLOCK_HZ / 1000 * PROG_TIME_MS;
  localparam int unsigned TIMER_W = 20;
  // ==========================================================
  // Sizes
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [1:0] PAGE_BYTES = 2'h2;
  // ==========================================================
  // Address byte layout and bit counter marks
  localparam logic [3:0] DEVICE_CODE = 4'h5; // Arbitrary value
  localparam int unsigned CODE_LSB = 4;
  localparam int unsigned CS_LSB = 1;
  localparam int unsigned RW_BIT = 0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  // ==========================================================
  // Reset values
  localparam logic [6:0] PTR_RESET = 7'h00;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WORD, ST_DATA, ST_READ} slave_state_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_sample_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } prog_entry_t;
endpackage

/* eeprom_slave.sv */
// Two-wire serial memory slave: bus protocol, page buffer and program timing
// How it works
// - Eighth address bit low writes, high reads.
// - Acknowledge address only if matched and idle.
// - Write address acknowledged on ninth clock.
// - Word byte loads pointer, top bit ignored.
// - Acknowledge data, hold up to two bytes.
// - Third data byte abandons write, array untouched.
// - Stop after one byte programs that byte.
// - Stop starts N millisecond program cycle.
// - Read sends byte at pointer, then increments.
// - Master acknowledge continues, stop ends reads.
// - Pointer wraps inside the 128-byte block.
// - Select bits must equal strapped inputs.
// - Data line only pulled low or released.
// - Data changes only while clock low.
// - Start and stop are edges on high clock.
// - After master no-acknowledge, release data line.
`timescale 1ns/100ps
`default_nettype none
module eeprom_slave #(
  parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
  parameter int unsigned FIFO_DEPTH = eeprom_pkg::FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic chip_select_bit0_i,
  input wire logic chip_select_bit1_i,
  input wire logic chip_select_bit2_i,
  output logic program_busy_o
);
  localparam int unsigned ENTRY_W = $bits(eeprom_pkg::prog_entry_t);
  localparam int unsigned TW = eeprom_pkg::TIMER_W;

  eeprom_pkg::bus_sample_t sync1_reg;
  eeprom_pkg::bus_sample_t sync2_reg;
  eeprom_pkg::bus_sample_t prev_reg;
  eeprom_pkg::slave_state_t state_reg;
  logic [3:0] bitcnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic sda_oe_reg;
  logic sda_reg;
  logic master_ack_reg;
  logic [6:0] ptr_reg;
  eeprom_pkg::prog_entry_t page_reg [2];
  logic [1:0] data_count_reg;
  logic [1:0] push_left_reg;
  logic push_idx_reg;
  logic prog_active_reg;
  logic [TW-1:0] timer_reg;
  logic busy_reg;
  logic [7:0] rd_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  eeprom_pkg::prog_entry_t fifo_out;
  logic pop;

  // ==========================================================
  // Line sampling and bus events
  // The first stage feeds only the second; all decoding looks further down the chain
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      prev_reg <= '1;
    end else if (enable_i) begin
      sync1_reg <= '{scl: scl_i, sda: sda_i};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = sync2_reg.scl & ~prev_reg.scl;
  assign scl_fall = ~sync2_reg.scl & prev_reg.scl;
  assign start_det = sync2_reg.scl & prev_reg.scl & prev_reg.sda & ~sync2_reg.sda;
  assign stop_det = sync2_reg.scl & prev_reg.scl & ~prev_reg.sda & sync2_reg.sda;

  // ==========================================================
  // Byte decode
  logic busy_w;
  logic addr_match;
  logic ack_start;
  logic ack_end;
  logic addr_ack;
  logic word_ack;
  logic data_ack;
  logic data_over;
  logic rd_load;
  logic tx_shift;
  logic rd_release;

  assign busy_w = prog_active_reg | fifo_out_valid | (push_left_reg != 2'h0);
  assign addr_match = (shift_reg[7:eeprom_pkg::CODE_LSB] == eeprom_pkg::DEVICE_CODE)
    && (shift_reg[eeprom_pkg::CS_LSB +: 3] ==
        {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i});
  assign ack_start = scl_fall && (bitcnt_reg == eeprom_pkg::BYTE_BITS)
    && (state_reg != eeprom_pkg::ST_READ);
  assign ack_end = scl_fall && (bitcnt_reg == eeprom_pkg::ACK_BIT);
  assign addr_ack = ack_start && (state_reg == eeprom_pkg::ST_ADDR) && addr_match && !busy_w;
  assign word_ack = ack_start && (state_reg == eeprom_pkg::ST_WORD);
  assign data_ack = ack_start && (state_reg == eeprom_pkg::ST_DATA)
    && (data_count_reg < eeprom_pkg::PAGE_BYTES);
  assign data_over = ack_start && (state_reg == eeprom_pkg::ST_DATA)
    && (data_count_reg >= eeprom_pkg::PAGE_BYTES);
  assign rd_load = ack_end && (((state_reg == eeprom_pkg::ST_ADDR) && sda_oe_reg
    && shift_reg[eeprom_pkg::RW_BIT]) || ((state_reg == eeprom_pkg::ST_READ) && master_ack_reg));
  assign tx_shift = scl_fall && (state_reg == eeprom_pkg::ST_READ)
    && (bitcnt_reg >= 4'h1) && (bitcnt_reg < eeprom_pkg::BYTE_BITS);
  assign rd_release = scl_fall && (state_reg == eeprom_pkg::ST_READ)
    && (bitcnt_reg == eeprom_pkg::BYTE_BITS);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (enable_i) begin
      if (start_det || ack_end) begin
        bitcnt_reg <= 4'h0;
      end else if (scl_rise && bitcnt_reg < eeprom_pkg::ACK_BIT) begin
        bitcnt_reg <= bitcnt_reg + 4'h1;
      end
      if (scl_rise && bitcnt_reg < eeprom_pkg::BYTE_BITS) begin
        shift_reg <= {shift_reg[6:0], sync2_reg.sda};
      end
    end
  end

  // ==========================================================
  // Protocol state
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= eeprom_pkg::ST_IDLE;
    end else if (enable_i) begin
      if (start_det) begin
        state_reg <= eeprom_pkg::ST_ADDR;
      end else if (stop_det) begin
        state_reg <= eeprom_pkg::ST_IDLE;
      end else if (ack_start && state_reg == eeprom_pkg::ST_ADDR && !addr_ack) begin
        state_reg <= eeprom_pkg::ST_IDLE;
      end else if (data_over) begin
        // Dropping to idle discards the page so the later stop commits nothing
        state_reg <= eeprom_pkg::ST_IDLE;
      end else if (ack_end) begin
        unique case (state_reg)
          eeprom_pkg::ST_IDLE: state_reg <= eeprom_pkg::ST_IDLE;
          eeprom_pkg::ST_ADDR: state_reg <= shift_reg[eeprom_pkg::RW_BIT] ?
            eeprom_pkg::ST_READ : eeprom_pkg::ST_WORD;
          eeprom_pkg::ST_WORD: state_reg <= eeprom_pkg::ST_DATA;
          eeprom_pkg::ST_DATA: state_reg <= eeprom_pkg::ST_DATA;
          eeprom_pkg::ST_READ: state_reg <= master_ack_reg ?
            eeprom_pkg::ST_READ : eeprom_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      master_ack_reg <= 1'b0;
    end else if (enable_i) begin
      if (scl_rise && bitcnt_reg == eeprom_pkg::BYTE_BITS && state_reg == eeprom_pkg::ST_READ) begin
        master_ack_reg <= ~sync2_reg.sda;
      end
    end
  end

  // ==========================================================
  // Data line drive
  // Changes follow the falling clock edge after synchronisation, giving the output hold
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sda_oe_reg <= 1'b0;
      sda_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else if (enable_i) begin
      sda_reg <= 1'b0;
      if (start_det || stop_det) begin
        sda_oe_reg <= 1'b0;
      end else if (rd_load) begin
        sda_oe_reg <= ~rd_data[7];
        tx_reg <= {rd_data[6:0], 1'b0};
      end else if (tx_shift) begin
        sda_oe_reg <= ~tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end else if (ack_start) begin
        sda_oe_reg <= addr_ack | word_ack | data_ack;
      end else if (ack_end || rd_release) begin
        sda_oe_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Address pointer and page buffer
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_reg <= eeprom_pkg::PTR_RESET;
    end else if (enable_i) begin
      if (word_ack) begin
        ptr_reg <= shift_reg[6:0];
      end else if (data_ack || rd_load) begin
        ptr_reg <= ptr_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      page_reg[0] <= '0;
      page_reg[1] <= '0;
      data_count_reg <= 2'h0;
    end else if (enable_i) begin
      if (word_ack) begin
        data_count_reg <= 2'h0;
      end else if (data_ack) begin
        page_reg[data_count_reg[0]] <= '{addr: ptr_reg, data: shift_reg};
        data_count_reg <= data_count_reg + 2'h1;
      end
    end
  end

  // Only a stop reached in the data phase commits, so a restart for a random read costs nothing
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      push_left_reg <= 2'h0;
      push_idx_reg <= 1'b0;
    end else if (enable_i) begin
      if (stop_det && state_reg == eeprom_pkg::ST_DATA && push_left_reg == 2'h0) begin
        push_left_reg <= data_count_reg;
        push_idx_reg <= 1'b0;
      end else if (push_left_reg != 2'h0 && fifo_in_ready) begin
        push_left_reg <= push_left_reg - 2'h1;
        push_idx_reg <= ~push_idx_reg;
      end
    end
  end

  prog_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) fifo_u (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(enable_i),
    .in_valid_i(push_left_reg != 2'h0),
    .in_ready_o(fifo_in_ready),
    .in_data_i(page_reg[push_idx_reg]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!prog_active_reg),
    .out_data_o(fifo_out)
  );

  // ==========================================================
  // Program engine: one byte per timed slot
  assign pop = fifo_out_valid && !prog_active_reg;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prog_active_reg <= 1'b0;
      timer_reg <= '0;
      busy_reg <= 1'b0;
    end else if (enable_i) begin
      busy_reg <= busy_w;
      if (pop) begin
        prog_active_reg <= 1'b1;
        timer_reg <= TW'(PROG_CYCLES - 1);
      end else if (prog_active_reg) begin
        if (timer_reg == '0) begin
          prog_active_reg <= 1'b0;
        end else begin
          timer_reg <= timer_reg - 1'b1;
        end
      end
    end
  end

  cell_array #(
    .ADDR_W(eeprom_pkg::ADDR_W),
    .DATA_W(eeprom_pkg::DATA_W)
  ) array_u (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(enable_i),
    .wr_en_i(pop),
    .wr_addr_i(fifo_out.addr),
    .wr_data_i(fifo_out.data),
    .rd_addr_i(ptr_reg),
    .rd_data_o(rd_data)
  );

  assign sda_o = sda_reg;
  assign sda_oe_o = sda_oe_reg;
  assign program_busy_o = busy_reg;

  // ==========================================================
  // Checks
  logic [TW:0] prog_len_reg;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prog_len_reg <= '0;
    end else if (enable_i) begin
      if (pop) begin
        prog_len_reg <= '0;
      end else if (prog_active_reg) begin
        prog_len_reg <= prog_len_reg + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock_i iff enable_i);
  endclocking
  default disable iff (!reset_n_i);

  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  a_ack_when_idle: assert property ($rose(sda_oe_reg) && state_reg == eeprom_pkg::ST_ADDR
    |-> !$past(busy_w) && $past(addr_match))
    else $error("address acknowledged while busy or unmatched");
  a_oe_clock_low: assert property ($changed(sda_oe_reg) && !$past(start_det) && !$past(stop_det)
    |-> !sync2_reg.scl || !$past(sync2_reg.scl))
    else $error("data line changed with clock high");
  a_word_to_ptr: assert property (word_ack |=> ptr_reg == $past(shift_reg[6:0]))
    else $error("word address not loaded");
  a_ptr_wraps: assert property (rd_load && ptr_reg == 7'h7F |=> ptr_reg == 7'h00)
    else $error("pointer did not wrap");
  a_over_abandon: assert property (data_over |=> state_reg == eeprom_pkg::ST_IDLE && !sda_oe_reg
    ##1 (push_left_reg == 2'h0))
    else $error("overlong page not abandoned");
  a_single_byte: assert property (stop_det && state_reg == eeprom_pkg::ST_DATA
    && data_count_reg == 2'h1 && push_left_reg == 2'h0 |=> push_left_reg == 2'h1)
    else $error("single byte not committed alone");
  a_prog_length: assert property ($fell(prog_active_reg) |-> prog_len_reg == (TW+1)'(PROG_CYCLES))
    else $error("program slot length wrong");
  a_nack_release: assert property (ack_end && state_reg == eeprom_pkg::ST_READ && !master_ack_reg
    |=> !sda_oe_reg && state_reg == eeprom_pkg::ST_IDLE)
    else $error("line not released after master no-acknowledge");
  a_read_advance: assert property (rd_load |=> ptr_reg == $past(ptr_reg) + 7'h01
    && sda_oe_reg == ~$past(rd_data[7]))
    else $error("read byte not started or pointer not advanced");

  c_page_write: cover property (stop_det && state_reg == eeprom_pkg::ST_DATA && data_count_reg == 2'h2);
  c_seq_read: cover property (rd_load && state_reg == eeprom_pkg::ST_READ);
  c_overflow: cover property (data_over);
  c_busy_nack: cover property (ack_start && state_reg == eeprom_pkg::ST_ADDR && addr_match && busy_w);
endmodule
`default_nettype wire

/* eeprom_slave_tb.sv */
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/100ps
`default_nettype none
module eeprom_slave_tb;
  // Long enough that an address byte fits inside one program cycle
  localparam int unsigned PROG = 400;
  localparam logic [2:0] STRAP = 3'h5;
  logic clock = 1'b0;
  logic reset_n;
  logic scl;
  logic sda_line;
  logic sda_o;
  logic sda_oe;
  logic sda_pull;
  logic busy;
  logic [2:0] straps;
  logic enable = 1'b1;
  int failures = 0;
  int checks_done = 0;
  int busy_len = 0;

  always #5 clock = ~clock;
  // Open-drain wire with pull-up
  assign sda_line = ~((sda_oe & ~sda_o) | sda_pull);
  always @(posedge clock) if (busy === 1'b1) busy_len <= busy_len + 1;

  eeprom_slave #(.PROG_CYCLES(PROG), .FIFO_DEPTH(8)) eeprom_slave_inst (
    .clock_i(clock), .reset_n_i(reset_n), .enable_i(enable), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .chip_select_bit0_i(straps[0]), .chip_select_bit1_i(straps[1]),
    .chip_select_bit2_i(straps[2]), .program_busy_o(busy));
  bus_master_model #(.HALF(10)) bus_master_model_inst (
    .clock_i(clock), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(sda_pull));

  // ==========================================================
  // Checking and wrappers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(negedge clock) if (reset_n === 1'b1 && sda_oe === 1'b1) check(8'(sda_o), 8'h00, "drive level");

  task automatic start();
    bus_master_model_inst.start_cond();
  endtask
  task automatic stop();
    bus_master_model_inst.stop_cond();
  endtask
  task automatic wb(input logic [7:0] b, output logic a);
    bus_master_model_inst.write_byte(b, a);
  endtask
  task automatic rb(input logic a, output logic [7:0] b);
    bus_master_model_inst.read_byte(a, b);
  endtask

  function automatic logic [7:0] addr_byte(input logic [2:0] cs, input logic rd);
    return {eeprom_pkg::DEVICE_CODE, cs, rd};
  endfunction

  task automatic send_addr(input logic [2:0] cs, input logic rd, input logic exp);
    logic a;
    wb(addr_byte(cs, rd), a);
    check(8'(a), 8'(exp), "address ack");
  endtask

  task automatic write_seq(input logic [7:0] word, input logic [7:0] d [3], input int n);
    logic a;
    start();
    send_addr(STRAP, 1'b0, 1'b1);
    wb(word, a);
    check(8'(a), 8'h01, "word ack");
    for (int i = 0; i < n; i++) begin
      wb(d[i], a);
      check(8'(a), 8'(i < 2), "data ack");
    end
    busy_len = 0;
    stop();
  endtask

  task automatic finish_prog(input int n, input int extra);
    for (int t = 0; t < 3 * PROG + extra && busy !== 1'b0; t++) @(posedge clock);
    #1;
    check(8'(busy_len >= n * PROG + extra && busy_len <= n * PROG + extra + 4), 8'h01, "program span");
  endtask

  task automatic read_from(input logic [7:0] word, input logic [7:0] e [2], input int n);
    logic a;
    logic [7:0] b;
    start();
    send_addr(STRAP, 1'b0, 1'b1);
    wb(word, a);
    check(8'(a), 8'h01, "word ack");
    start();
    send_addr(STRAP, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      rb(i < n - 1, b);
      check(b, e[i], "read data");
    end
    repeat (5) @(posedge clock);
    #1;
    check(8'(sda_oe), 8'h00, "release after nack");
    stop();
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_select();
    logic a;
    for (int i = 0; i < 8; i++) begin
      start();
      send_addr(3'(i), 1'b0, 3'(i) == STRAP);
      stop();
    end
    start();
    wb({~eeprom_pkg::DEVICE_CODE, STRAP, 1'b0}, a);
    check(8'(a), 8'h00, "foreign code ack");
    stop();
  endtask

  task automatic s_byte_write();
    write_seq(8'h85, '{8'h3C, 8'h00, 8'h00}, 1);
    start();
    send_addr(STRAP, 1'b0, 1'b0);
    stop();
    finish_prog(1, 0);
    read_from(8'h05, '{8'h3C, 8'h00}, 1);
  endtask

  task automatic s_page_wrap();
    logic [7:0] b;
    write_seq(8'h7F, '{8'h11, 8'h22, 8'h00}, 2);
    finish_prog(2, 0);
    read_from(8'h7F, '{8'h11, 8'h22}, 2);
    read_from(8'h7F, '{8'h11, 8'h00}, 1);
    start();
    send_addr(STRAP, 1'b1, 1'b1);
    rb(1'b0, b);
    check(b, 8'h22, "current read");
    stop();
  endtask

  task automatic s_overflow();
    write_seq(8'h05, '{8'h01, 8'h02, 8'h03}, 3);
    finish_prog(0, 0);
    read_from(8'h05, '{8'h3C, 8'h00}, 1);
  endtask

  // Enable low mid-commit must stretch the program cycle, not lose the byte
  task automatic s_freeze();
    write_seq(8'h10, '{8'hA5, 8'h00, 8'h00}, 1);
    enable = 1'b0;
    repeat (100) @(posedge clock);
    #1;
    enable = 1'b1;
    finish_prog(1, 100);
    read_from(8'h10, '{8'hA5, 8'h00}, 1);
  endtask

  initial begin
    reset_n = 1'b0;
    straps = STRAP;
    repeat (4) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    s_select();
    s_byte_write();
    s_page_wrap();
    s_overflow();
    s_freeze();
    final_report();
  end

  // Whole run needs some 11000 cycles
  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire

/* prog_fifo.sv */
// Small FIFO carrying committed bytes to the program engine
`timescale 1ns/100ps
`default_nettype none
module prog_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = count_reg != (PTR_W+1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o = store_reg[rd_ptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clock_i) begin
    if (enable_i && push) begin
      store_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (enable_i) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
